//--- dv/tmsf_host.sv
// Host model: byte writes, byte reads and alert response completion.
// Assumes the bus engine hands each byte over as one strobed cycle.
`timescale 1ns/1ps
`default_nettype none
module tmsf_host (
    // Clock
    input wire logic core_clk,
    // Register side
    output var logic [7:0] reg_ptr,
    output var logic reg_wr,
    output var logic [7:0] reg_wdata,
    output var logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Alert response
    output var logic ara_done
);
    // Bus idle from time zero.
    initial begin
        reg_ptr = 8'h00;
        reg_wr = 1'h0;
        reg_wdata = 8'h00;
        reg_rd = 1'h0;
        ara_done = 1'h0;
    end
    // Write data is inverted once released so stale bytes never look valid.
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_ptr = p;
        reg_wdata = d;
        reg_wr = 1'h1;
        @(posedge core_clk);
        #1;
        reg_wr = 1'h0;
        reg_wdata = ~d;
    endtask
    // The pointer is set with the read strobe and is taken at the same edge.
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_ptr = p;
        reg_rd = 1'h1;
        @(posedge core_clk);
        #1;
        reg_rd = 1'h0;
        d = reg_rdata;
    endtask
    // In alert mode only this transaction may release the alert pin.
    task automatic ara();
        @(posedge core_clk);
        #1;
        ara_done = 1'h1;
        @(posedge core_clk);
        #1;
        ara_done = 1'h0;
    endtask
endmodule
`default_nettype wire

//--- dv/tmsf_status_props.sv
// Checker on the status block ports: start, busy, latches, alert pin, mode.
// Assumes one clock domain; bound into every status block instance.
`timescale 1ns/1ps
`default_nettype none
module tmsf_status_props #(
    parameter bit DUAL = 1'b0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register access
    input wire logic [7:0] reg_ptr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Converter side
    input wire logic ara_done,
    input wire logic conv_start,
    input wire logic conv_busy,
    input wire logic [tmsf_pkg::NUM_CH-1:0] ch_done,
    input wire logic [tmsf_pkg::NUM_CH-1:0] ch_remote_open,
    input wire logic [tmsf_pkg::NUM_CH*8-1:0] ch_temp,
    input wire logic [tmsf_pkg::NUM_CH*8-1:0] ch_high_lim,
    input wire logic [tmsf_pkg::NUM_CH*8-1:0] ch_crit_lim,
    // Pins
    input wire logic alert_output_pin_n,
    input wire logic high_limit_comparator_mode
);
    import tmsf_pkg::*;
    // Short names for the causes the properties watch.
    wire logic srd;
    wire logic lcr;
    wire logic hi1;
    wire logic al;
    wire logic md;
    assign srd = reg_rd && reg_ptr == PTR_STATUS;
    assign lcr = ch_done[0] && ch_temp[7:0] > ch_crit_lim[7:0];
    assign hi1 = ch_done[1] && ch_temp[15:8] > ch_high_lim[15:8];
    assign al = alert_output_pin_n;
    assign md = high_limit_comparator_mode;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // A quiet cycle, then a status read, with no new local result meanwhile.
    sequence s_gap;
        !ch_done[0] && !srd ##1 srd && !ch_done[0];
    endsequence
    AST_START: assert property ($fell(rst) |-> ##[1:200] conv_start)
        else $error("first conversion did not start");
    AST_BUSY: assert property (srd |=> reg_rdata[ST_BUSY] == $past(conv_busy))
        else $error("busy bit does not follow the converter");
    AST_CRIT: assert property (lcr ##1 s_gap |=> reg_rdata[DUAL ? ST_CRIT : ST_LCRIT])
        else $error("critical flag not set");
    AST_OPEN: assert property (ch_remote_open[1] ##1 s_gap |=> reg_rdata[ST_OPEN])
        else $error("open flag not latched");
    AST_HOLD: assert property (!al && !ara_done && !md ##1 !md |-> !al)
        else $error("alert released without alert response");
    AST_REL: assert property (ara_done && !md && !(|ch_done) ##1 !md |-> al)
        else $error("alert not released by alert response");
    AST_CMP: assert property (md && hi1 ##1 md |-> ##[0:1] !al)
        else $error("comparator mode pin did not go low");
    AST_MODE: assert property (reg_wr && reg_ptr == PTR_CFG1_WR |=>
        md == $past(reg_wdata[CFG1_MODE_BIT])) else $error("mode select not taken");
endmodule
bind tmsf_status tmsf_status_props #(.DUAL(DUAL)) u_props (
    .core_clk(core_clk), .rst(rst), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ara_done(ara_done),
    .conv_start(conv_start), .conv_busy(conv_busy), .ch_done(ch_done),
    .ch_remote_open(ch_remote_open), .ch_temp(ch_temp), .ch_high_lim(ch_high_lim),
    .ch_crit_lim(ch_crit_lim), .alert_output_pin_n(alert_output_pin_n),
    .high_limit_comparator_mode(high_limit_comparator_mode));
`default_nettype wire

//--- dv/tmsf_status_test.sv
// Bench for both status variants side by side with limits high 55, low 10, crit 60.
// Assumes the host model on the register side; results are driven from here.
`timescale 1ns/1ps
`default_nettype none
module tmsf_status_test;
    import tmsf_pkg::*;
    logic core_clk = 1'h0, rst = 1'h1, conv_busy = 1'h0;
    logic [2:0] ch_done = 3'h0, ch_open = 3'h0;
    logic [23:0] ch_temp = {3{8'h30}};
    logic [7:0] rv;
    wire logic [7:0] reg_ptr, reg_wdata, reg_rdata;
    wire logic reg_wr, reg_rd, ara_done, conv_start, al, md;
    wire logic [7:0] rd2;
    wire logic al2, md2, cs2;
    int failures = 0, num_checks = 0, n;
    tmsf_host h (.core_clk(core_clk), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ara_done(ara_done));
    tmsf_status #(.DUAL(1'b0), .W(8)) uut (.core_clk(core_clk), .rst(rst), .reg_ptr(reg_ptr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ara_done(ara_done), .conv_start(conv_start), .conv_busy(conv_busy), .ch_done(ch_done),
        .ch_remote_open(ch_open), .ch_temp(ch_temp), .ch_high_lim({3{8'h55}}),
        .ch_low_lim({3{8'h10}}), .ch_crit_lim({3{8'h60}}), .alert_output_pin_n(al),
        .high_limit_comparator_mode(md));
    // Dual-remote copy on the same bus and results; its read data stand after each read.
    tmsf_status #(.DUAL(1'b1), .W(8)) uut2 (.core_clk(core_clk), .rst(rst), .reg_ptr(reg_ptr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(rd2),
        .ara_done(ara_done), .conv_start(cs2), .conv_busy(conv_busy), .ch_done(ch_done),
        .ch_remote_open(ch_open), .ch_temp(ch_temp), .ch_high_lim({3{8'h55}}),
        .ch_low_lim({3{8'h10}}), .ch_crit_lim({3{8'h60}}), .alert_output_pin_n(al2),
        .high_limit_comparator_mode(md2));
    // Free running 125 MHz clock.
    always #4 core_clk = ~core_clk;
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic st(input logic [7:0] e);
        h.rd(PTR_STATUS, rv);
        chk(rv, e);
    endtask
    task automatic pin(input logic e);
        chk({7'h00, al}, {7'h00, e});
    endtask
    // One end-of-conversion pulse for a channel with a new reading.
    task automatic conv(input int ch, input logic [7:0] t);
        @(posedge core_clk);
        #1;
        ch_temp[ch*8 +: 8] = t;
        ch_done[ch] = 1'h1;
        @(posedge core_clk);
        #1;
        ch_done[ch] = 1'h0;
    endtask
    // Return both channels to normal and clear every latch and the pin.
    task automatic tidy();
        conv(0, 8'h30);
        conv(1, 8'h30);
        h.rd(PTR_STATUS, rv);
        st(8'h00);
        h.ara();
    endtask
    task automatic t_start();
        st(STATUS_RST);
        chk(rd2, STATUS_RST);
        h.rd(PTR_HYST, rv);
        chk(rv, HYST_RST);
        h.wr(PTR_STATUS, 8'hff);
        st(8'h00);
        for (n = 0; n < 300 && conv_start !== 1'h1; n++) begin
            @(posedge core_clk);
            #1;
        end
        if (n == 300) begin
            failures++;
            $display("[ERR] %0t no conversion start", $time);
            end_of_test();
        end else begin
            chk({7'h00, cs2}, 8'h01);
            conv_busy = 1'h1;
            st(8'h80);
            conv_busy = 1'h0;
        end
    endtask
    task automatic t_alert();
        conv(0, 8'h58);
        st(8'h40);
        pin(1'h0);
        st(8'h40);
        conv(0, 8'h30);
        st(8'h40);
        st(8'h00);
        pin(1'h0);
        h.ara();
        pin(1'h1);
        conv(1, 8'h05);
        st(8'h08);
        pin(1'h0);
        tidy();
        @(posedge core_clk);
        #1;
        ch_open[1] = 1'h1;
        @(posedge core_clk);
        #1;
        ch_open[1] = 1'h0;
        st(8'h04);
        st(8'h00);
        pin(1'h0);
        h.ara();
    endtask
    // Hysteresis 0a: 57 keeps the flag, 56 is no longer above 60 less 0a.
    task automatic t_crit();
        for (int ch = 0; ch < 2; ch++) begin
            conv(ch, 8'h61);
            h.rd(PTR_STATUS, rv);
            chk(rv & 8'h03, ch == 0 ? 8'h01 : 8'h02);
            h.rd(PTR_STATUS, rv);
            chk(rv & 8'h03, ch == 0 ? 8'h01 : 8'h02);
            conv(ch, 8'h57);
            h.rd(PTR_STATUS, rv);
            chk(rv & 8'h03, ch == 0 ? 8'h01 : 8'h02);
            conv(ch, 8'h56);
            h.rd(PTR_STATUS, rv);
            chk(rv & 8'h03, 8'h00);
            tidy();
        end
    endtask
    // Live high flag: set above 55, kept at 4c, dropped at 55 less 0a.
    task automatic t_cmp();
        h.wr(PTR_CFG1_WR, 8'h20);
        h.rd(PTR_CFG1_RD, rv);
        chk(rv, 8'h20);
        conv(1, 8'h58);
        st(8'h10);
        st(8'h10);
        conv(1, 8'h4c);
        st(8'h10);
        pin(1'h0);
        conv(1, 8'h4b);
        st(8'h00);
        pin(1'h1);
        h.wr(PTR_CFG1_WR, 8'h00);
    endtask
    // Channel 2 readings only reach the merged flags of the dual block, never the single one.
    task automatic t_dual();
        conv(2, 8'h61);
        h.rd(PTR_STATUS, rv);
        chk(rv, 8'h00);
        chk(rd2, 8'h12);
        chk({7'h00, al2}, 8'h00);
        conv(2, 8'h30);
        h.rd(PTR_STATUS, rv);
        chk(rd2, 8'h10);
        h.rd(PTR_STATUS, rv);
        chk(rd2, 8'h00);
        conv(2, 8'h05);
        h.rd(PTR_STATUS, rv);
        chk(rd2, 8'h08);
        conv(2, 8'h30);
        h.rd(PTR_STATUS, rv);
        h.rd(PTR_STATUS, rv);
        chk(rd2, 8'h00);
        chk({7'h00, al2}, 8'h00);
        h.ara();
        chk({7'h00, al2}, 8'h01);
        h.wr(PTR_CFG1_WR, 8'h20);
        chk({7'h00, md2}, 8'h01);
        conv(2, 8'h58);
        h.rd(PTR_STATUS, rv);
        chk(rv, 8'h00);
        chk(rd2, 8'h10);
        chk({7'h00, al2}, 8'h00);
        conv(2, 8'h4b);
        h.rd(PTR_STATUS, rv);
        chk(rd2, 8'h00);
        chk({7'h00, al2}, 8'h01);
        h.wr(PTR_CFG1_WR, 8'h00);
    endtask
    task automatic end_of_test();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Reset for four cycles, then the scenarios in turn.
    initial begin
        repeat (4) @(posedge core_clk);
        #1;
        rst = 1'h0;
        t_start();
        t_alert();
        t_crit();
        t_cmp();
        t_dual();
        end_of_test();
    end
endmodule
`default_nettype wire

//--- inc/tmsf_pkg.sv
// Package for the temperature monitor status flag block.
// Assumes a single 125 MHz core clock and an 8-bit register pointer from the bus engine.
package tmsf_pkg;
    // Register pointers.
    localparam logic [7:0] PTR_STATUS = 8'h02;
    localparam logic [7:0] PTR_HYST = 8'h21;
    localparam logic [7:0] PTR_CFG1_RD = 8'h03;
    localparam logic [7:0] PTR_CFG1_WR = 8'h09;
    // Reset values.
    localparam logic [7:0] HYST_RST = 8'h0a;
    localparam logic [7:0] CFG1_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    // Configuration register 1 field positions.
    localparam int CFG1_MODE_BIT = 5;
    // Status bit positions, single-remote variant.
    localparam int ST_BUSY = 7;
    localparam int ST_LOCAL_HIGH_FLAG = 6;
    localparam int ST_LOCAL_LOW_FLAG = 5;
    localparam int ST_REMOTE_HIGH_FLAG = 4;
    localparam int ST_REMOTE_LOW_FLAG = 3;
    localparam int ST_OPEN = 2;
    localparam int ST_RCRIT = 1;
    localparam int ST_LCRIT = 0;
    // Status bit positions, dual-remote variant.
    localparam int ST_HIGH = 4;
    localparam int ST_LOW = 3;
    localparam int ST_CRIT = 1;
    // First conversion start after reset.
    localparam int CLK_MHZ = 125;
    localparam int START_DELAY_NS = 1000;
    localparam int START_DELAY_CYC = (START_DELAY_NS * CLK_MHZ) / 1000;
    // Channel indices.
    localparam int CH_LOCAL = 0;
    localparam int CH_REMOTE1 = 1;
    localparam int CH_REMOTE2 = 2;
    localparam int NUM_CH = 3;
    // Sequencer states.
    typedef enum logic [2:0] {
        SEQ_WAIT = 3'b001,
        SEQ_START = 3'b010,
        SEQ_CONV = 3'b100
    } tmsf_seq_t;
endpackage

//--- rtl/tmsf_hyst_cmp.sv
// Live hysteresis comparator for one channel against one limit.
// Assumes temperature, limit and hysteresis are unsigned bytes and update
// only on the end-of-conversion strobe given to it.
`timescale 1ns/1ps
`default_nettype none
module tmsf_hyst_cmp #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Conversion result
    input wire logic upd,
    input wire logic [W-1:0] temp,
    input wire logic [W-1:0] limit,
    input wire logic [W-1:0] hyst,
    // Comparator state
    output logic flag_ff
);
    logic [W:0] release_lvl;
    logic nxt_flag;

    // Release level saturates at zero so a large hysteresis cannot wrap.
    assign release_lvl = ({1'b0, limit} > {1'b0, hyst}) ?
        ({1'b0, limit} - {1'b0, hyst}) : '0;
    assign nxt_flag = flag_ff ? ({1'b0, temp} > release_lvl) : (temp > limit);

    // The flag moves only at the end of a conversion of this channel.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flag_ff <= 1'b0;
        end else if (upd) begin
            flag_ff <= nxt_flag;
        end
    end
endmodule
`default_nettype wire

//--- rtl/tmsf_status.sv
// Status flags, hysteresis and alert logic of a remote/local temperature monitor.
// Assumes the bus engine gives pointer, write and read strobes, and that the
// converter reports per-channel end-of-conversion results and open detections.
// How it works
// - Status at pointer 02h, writes ignored
// - Single-remote bit layout, reset zero
// - Dual-remote merged layout, D6 D5 D0 zero
// - Busy mirrors converter activity
// - First conversion starts soon after reset
// - Open flag latches on remote conversion detect
// - Remote critical flag with hysteresis
// - Local critical flag with hysteresis
// - Alert mode: high flags latch
// - Comparator mode: high flags live with hysteresis
// - Low flags always latch
// - Read clears latched flag if condition gone
// - Live flags update per conversion, read-immune
// - Status read does not release alert
// - Single-remote alert on rising ORed high flags, ORed low flags, open
// - Dual critical flag from any channel
// - Dual high latches in alert mode
// - Dual high live in comparator mode
// - Dual low always latches
// - Dual alert on rising high, low, open
// - Hysteresis byte at 21h, reset 0Ah
// - Mode select is config 1 bit 5
`timescale 1ns/1ps
`default_nettype none
module tmsf_status #(
    parameter bit DUAL = 1'b0,
    parameter int W = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register access from the bus engine
    input wire logic [7:0] reg_ptr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Alert response address transaction completed
    input wire logic ara_done,
    // Converter handshake
    output logic conv_start,
    input wire logic conv_busy,
    // Per-channel conversion results
    input wire logic [tmsf_pkg::NUM_CH-1:0] ch_done,
    input wire logic [tmsf_pkg::NUM_CH-1:0] ch_remote_open,
    input wire logic [tmsf_pkg::NUM_CH*8-1:0] ch_temp,
    input wire logic [tmsf_pkg::NUM_CH*8-1:0] ch_high_lim,
    input wire logic [tmsf_pkg::NUM_CH*8-1:0] ch_low_lim,
    input wire logic [tmsf_pkg::NUM_CH*8-1:0] ch_crit_lim,
    // Pin and mode outputs
    output logic alert_output_pin_n,
    output logic high_limit_comparator_mode
);
    import tmsf_pkg::*;

    localparam int NCH = DUAL ? 3 : 2;

    logic [7:0] hyst_ff;
    logic [7:0] cfg1_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [15:0] start_cnt_ff;
    tmsf_seq_t seq_ff;
    tmsf_seq_t nxt_seq;
    logic mode_cmp;
    logic status_rd;
    logic [NUM_CH-1:0] high_cmp;
    logic [NUM_CH-1:0] crit_cmp;
    logic [NUM_CH-1:0] high_hit;
    logic [NUM_CH-1:0] low_hit;
    logic [NUM_CH-1:0] high_now;
    logic [NUM_CH-1:0] low_now;
    logic [NUM_CH-1:0] high_lat_ff;
    logic [NUM_CH-1:0] low_lat_ff;
    logic [NUM_CH-1:0] nxt_high_lat;
    logic [NUM_CH-1:0] nxt_low_lat;
    logic open_ff;
    logic nxt_open;
    logic open_hit;
    logic [7:0] status_word;
    logic [2:0] alert_src;
    logic [2:0] alert_src_ff;
    logic alert_set;
    logic alert_ff;

    // Picks one byte lane out of a packed channel bus.
    function automatic logic [7:0] lane(input logic [NUM_CH*8-1:0] bus, input int ch);
        lane = bus[ch*8 +: 8];
    endfunction

    // Mode select decoding, zero for alert mode.
    assign mode_cmp = cfg1_ff[CFG1_MODE_BIT];
    assign high_limit_comparator_mode = mode_cmp;
    // Only a read at the status pointer touches the latches; writes there fall through.
    assign status_rd = reg_rd && (reg_ptr == PTR_STATUS);

    // Hysteresis and configuration registers, the only writable state here.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hyst_ff <= HYST_RST;
            cfg1_ff <= CFG1_RST;
        end else if (reg_wr) begin
            if (reg_ptr == PTR_HYST) begin
                hyst_ff <= reg_wdata;
            end
            if (reg_ptr == PTR_CFG1_WR) begin
                cfg1_ff <= reg_wdata;
            end
        end
    end

    // Per-channel live comparators: high limit and critical limit.
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            tmsf_hyst_cmp #(.W(8)) u_high (
                .core_clk(core_clk),
                .rst(rst),
                .upd(ch_done[g]),
                .temp(lane(ch_temp, g)),
                .limit(lane(ch_high_lim, g)),
                .hyst(hyst_ff),
                .flag_ff(high_cmp[g])
            );
            tmsf_hyst_cmp #(.W(8)) u_crit (
                .core_clk(core_clk),
                .rst(rst),
                .upd(ch_done[g]),
                .temp(lane(ch_temp, g)),
                .limit(lane(ch_crit_lim, g)),
                .hyst(hyst_ff),
                .flag_ff(crit_cmp[g])
            );
            // A crossing seen at the end of this channel's conversion.
            assign high_hit[g] = ch_done[g] && (g < NCH) &&
                (lane(ch_temp, g) > lane(ch_high_lim, g));
            assign low_hit[g] = ch_done[g] && (g < NCH) &&
                (lane(ch_temp, g) < lane(ch_low_lim, g));
        end
    endgenerate

    // Present condition, held from the latest conversion, used to block a clear.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            high_now <= '0;
            low_now <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (ch_done[i]) begin
                    high_now[i] <= high_hit[i];
                    low_now[i] <= low_hit[i];
                end
            end
        end
    end

    // A new crossing wins over a clear in the same cycle; a read only clears
    // flags whose cause is gone.
    assign nxt_high_lat = high_hit |
        (high_lat_ff & ~(status_rd ? ~high_now : '0));
    assign nxt_low_lat = low_hit |
        (low_lat_ff & ~(status_rd ? ~low_now : '0));
    assign open_hit = |(ch_remote_open & ~(NUM_CH'(1) << CH_LOCAL));
    assign nxt_open = open_hit | (open_ff & ~status_rd);

    // Latched flags; the high latch is held clear in comparator mode.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            high_lat_ff <= '0;
            low_lat_ff <= '0;
            open_ff <= 1'b0;
        end else begin
            high_lat_ff <= mode_cmp ? '0 : nxt_high_lat;
            low_lat_ff <= nxt_low_lat;
            open_ff <= nxt_open;
        end
    end

    // Status word assembly for the two variants.
    always_comb begin
        status_word = STATUS_RST;
        status_word[ST_BUSY] = conv_busy;
        status_word[ST_OPEN] = open_ff;
        if (DUAL) begin
            status_word[ST_HIGH] = mode_cmp ? |high_cmp : |high_lat_ff;
            status_word[ST_LOW] = |low_lat_ff;
            status_word[ST_CRIT] = |crit_cmp;
        end else begin
            status_word[ST_LOCAL_HIGH_FLAG] = mode_cmp ? high_cmp[CH_LOCAL] :
                high_lat_ff[CH_LOCAL];
            status_word[ST_REMOTE_HIGH_FLAG] = mode_cmp ? high_cmp[CH_REMOTE1] :
                high_lat_ff[CH_REMOTE1];
            status_word[ST_LOCAL_LOW_FLAG] = low_lat_ff[CH_LOCAL];
            status_word[ST_REMOTE_LOW_FLAG] = low_lat_ff[CH_REMOTE1];
            status_word[ST_RCRIT] = crit_cmp[CH_REMOTE1];
            status_word[ST_LCRIT] = crit_cmp[CH_LOCAL];
        end
    end

    // Read data mux; unmapped pointers read zero.
    assign nxt_rdata = (reg_ptr == PTR_STATUS) ? status_word :
        (reg_ptr == PTR_HYST) ? hyst_ff :
        (reg_ptr == PTR_CFG1_RD) ? cfg1_ff : 8'h00;

    // Read data is registered so it matches the status snapshot before clearing.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata = rdata_ff;

    // Sources that pull the alert pin, as seen in the status word.
    assign alert_src = DUAL ?
        {status_word[ST_HIGH], status_word[ST_LOW], open_ff} :
        {status_word[ST_LOCAL_HIGH_FLAG] | status_word[ST_REMOTE_HIGH_FLAG],
         status_word[ST_LOCAL_LOW_FLAG] | status_word[ST_REMOTE_LOW_FLAG], open_ff};

    // Any zero-to-one change of a source in alert mode sets the alert.
    assign alert_set = !mode_cmp && |(alert_src & ~alert_src_ff);

    // Alert is held until an alert response; a status read has no say.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            alert_src_ff <= 3'h0;
            alert_ff <= 1'b0;
        end else begin
            alert_src_ff <= alert_src;
            if (alert_set) begin
                alert_ff <= 1'b1;
            end else if (ara_done) begin
                alert_ff <= 1'b0;
            end
        end
    end

    // In comparator mode the pin follows the live high flags instead.
    assign alert_output_pin_n = mode_cmp ? ~(|high_cmp[NCH-1:0]) : ~alert_ff;

    // Start counter for the first conversion after reset.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            start_cnt_ff <= 16'h0000;
        end else if (seq_ff == SEQ_WAIT) begin
            start_cnt_ff <= start_cnt_ff + 16'h0001;
        end
    end

    // Sequencer that kicks off the first conversion soon after reset.
    always_comb begin
        case (seq_ff)
            SEQ_WAIT: begin
                nxt_seq = (start_cnt_ff >= 16'(START_DELAY_CYC - 1)) ? SEQ_START : SEQ_WAIT;
            end
            SEQ_START: begin
                nxt_seq = SEQ_CONV;
            end
            SEQ_CONV: begin
                nxt_seq = SEQ_CONV;
            end
            default: begin
                nxt_seq = SEQ_WAIT;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seq_ff <= SEQ_WAIT;
        end else begin
            seq_ff <= nxt_seq;
        end
    end
    assign conv_start = (seq_ff == SEQ_START);
endmodule
`default_nettype wire
